/* hw/swp_pkg.sv */
// Constants, opcodes and types of the status write protection block.
package swp_pkg;
	localparam int CLK_MHZ = 50;
	localparam int PUW_US = 10;
	localparam int PUW_CYC = PUW_US * CLK_MHZ;
	localparam int TW_US = 100;
	localparam int TW_CYC = TW_US * CLK_MHZ;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_VWREN = 8'h50;
	localparam logic [7:0] OP_WRSR1 = 8'h01;
	localparam logic [7:0] OP_WRSR2 = 8'h31;
	localparam logic [7:0] OP_WRSR3 = 8'h11;
	localparam logic [7:0] OP_RDSR1 = 8'h05;
	localparam logic [7:0] OP_RDSR2 = 8'h35;
	localparam logic [7:0] OP_RDSR3 = 8'h15;
	localparam logic [7:0] OP_SUSP = 8'h75;
	localparam logic [7:0] OP_RESM = 8'h7a;
	localparam logic [7:0] OP_DPD = 8'hb9;
	localparam logic [7:0] OP_REL = 8'hab;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_BE = 8'hd8;
	localparam logic [7:0] OP_CE = 8'hc7;
	localparam logic [7:0] SR_RESET = 8'h00;
	localparam logic [7:0] SR1_CFG_MASK = 8'hfc;
	localparam logic [7:0] SR2_CFG_MASK = 8'h42;
	localparam logic [7:0] SR2_OTP_MASK = 8'h38;
	localparam logic [7:0] SR3_CFG_MASK = 8'hf0;
	localparam int SR1_LOCK = 7;
	localparam int SR2_QE = 1;
	localparam int SR3_HOLD_OR_RESTART_SELECT = 7;
	localparam logic [6:0] PCT_00 = 7'd50;
	localparam logic [6:0] PCT_01 = 7'd25;
	localparam logic [6:0] PCT_10 = 7'd75;
	localparam logic [6:0] PCT_11 = 7'd100;
	typedef enum logic [1:0] {
		PIN_CS, PIN_SCLK, PIN_DI, PIN_WP
	} swp_pin_t;
	typedef struct packed {
		logic quad_io_enable;
		logic hold_or_restart_select;
		logic [1:0] drive_strength_field;
		logic quad_fast_mode_bit;
		logic invert_protection_bit;
		logic status_lock_bit;
		logic small_granule_select;
		logic top_bottom_select;
		logic [2:0] protect_range_bits;
	} swp_cfg_t;
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic di;
		logic wp_n;
		logic hold_n;
	} swp_pins_t;
endpackage

/* hw/swp_status_protect.sv */
// Status register protection, configuration and write-disable logic.
`timescale 1ns/10ps
module swp_status_protect #(
	parameter int BUSY_CYCLES = swp_pkg::TW_CYC
) (
	// Clock and power-on reset.
	input wire logic clock,
	input wire logic srst,
	// Serial pins in, asynchronous to clock; data out and its enable registered on clock.
	input wire swp_pkg::swp_pins_t pins,
	output logic do_out,
	output logic do_oe,
	// Status and configuration.
	output logic [7:0] status_byte_one,
	output logic [7:0] status_byte_two,
	output logic [7:0] status_byte_three,
	output swp_pkg::swp_cfg_t cfg,
	output logic [6:0] drive_pct,
	output logic hold_active,
	output logic pin_restart,
	output logic deep_sleep_state
);
	typedef enum logic [1:0] {
		MODE_POWERUP, MODE_READY, MODE_BUSY, MODE_SLEEP
	} swp_mode_t;
	swp_pkg::swp_pins_t s1_reg, s2_reg;
	logic sclk_prev_reg, cs_prev_reg;
	logic [2:0] bit_cnt_reg, out_cnt_reg;
	logic [1:0] byte_cnt_reg;
	logic [7:0] shift_reg, opcode_reg, d1_reg, d2_reg;
	logic [7:0] nv1_reg, nv2_reg, nv3_reg, vol1_reg, vol2_reg, vol3_reg;
	logic wel_reg, vwe_reg, sus_reg, arr_reg, rd_reg;
	logic [1:0] rd_sel_reg;
	swp_mode_t mode_reg;
	logic [15:0] cnt_reg;
	logic qe, hold_pin, rst_pin, sclk_rise, sclk_fall, cs_rise, exec;
	logic is_wr, is_pe, is_rd, wr_class, go, locked, wr_ok, nv_wr, v_wr;
	logic [7:0] byte_in, sr1, sr2, sr3, w2;

	// Pin synchronisers; only the second stage is looked at.
	always_ff @(posedge clock) begin
		s1_reg <= pins;
		s2_reg <= s1_reg;
		sclk_prev_reg <= s2_reg.sclk;
		cs_prev_reg <= s2_reg.cs_n;
	end

	assign qe = vol2_reg[swp_pkg::SR2_QE];
	assign hold_pin = ~qe & ~vol3_reg[swp_pkg::SR3_HOLD_OR_RESTART_SELECT] & ~s2_reg.hold_n;
	assign rst_pin = ~qe & vol3_reg[swp_pkg::SR3_HOLD_OR_RESTART_SELECT] & ~s2_reg.hold_n;
	assign sclk_rise = s2_reg.sclk & ~sclk_prev_reg & ~s2_reg.cs_n & ~hold_pin;
	assign sclk_fall = ~s2_reg.sclk & sclk_prev_reg & ~s2_reg.cs_n & ~hold_pin;
	assign cs_rise = s2_reg.cs_n & ~cs_prev_reg;
	assign byte_in = {shift_reg[6:0], s2_reg.di};
	// A frame only executes when it ended on a whole byte.
	assign exec = cs_rise & ~rst_pin & (bit_cnt_reg == 3'd0)
		& (byte_cnt_reg != 2'd0);

	always_comb begin
		is_wr = opcode_reg inside {swp_pkg::OP_WRSR1, swp_pkg::OP_WRSR2,
			swp_pkg::OP_WRSR3};
		is_pe = (opcode_reg == swp_pkg::OP_PP) | (opcode_reg == swp_pkg::OP_SE)
			| (opcode_reg == swp_pkg::OP_BE) | (opcode_reg == swp_pkg::OP_CE);
		is_rd = (byte_in == swp_pkg::OP_RDSR1) | (byte_in == swp_pkg::OP_RDSR2)
			| (byte_in == swp_pkg::OP_RDSR3);
		wr_class = is_wr | is_pe | (opcode_reg == swp_pkg::OP_WREN)
			| (opcode_reg == swp_pkg::OP_VWREN);
		// Busy and sleep swallow commands; power-up only blocks writes.
		go = exec & ((mode_reg == MODE_READY)
			| ((mode_reg == MODE_POWERUP) & ~wr_class));
		// With quad enabled the protect pin is a data line and unlocks.
		locked = vol1_reg[swp_pkg::SR1_LOCK] & ~(qe | s2_reg.wp_n);
		wr_ok = go & is_wr & ~locked;
		v_wr = wr_ok & vwe_reg;
		nv_wr = wr_ok & ~vwe_reg & wel_reg;
		w2 = (opcode_reg == swp_pkg::OP_WRSR1) ? d2_reg : d1_reg;
	end

	// Serial frame capture.
	always_ff @(posedge clock) begin
		if (srst | s2_reg.cs_n | rst_pin) begin
			bit_cnt_reg <= 3'd0;
			byte_cnt_reg <= 2'd0;
			shift_reg <= 8'h00;
		end else if (sclk_rise) begin
			shift_reg <= byte_in;
			bit_cnt_reg <= bit_cnt_reg + 3'd1;
			if (bit_cnt_reg == 3'd7) begin
				if (byte_cnt_reg != 2'd3) begin
					byte_cnt_reg <= byte_cnt_reg + 2'd1;
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			opcode_reg <= 8'h00;
			d1_reg <= 8'h00;
			d2_reg <= 8'h00;
		end else if (sclk_rise && bit_cnt_reg == 3'd7) begin
			unique case (byte_cnt_reg)
				2'd0: opcode_reg <= byte_in;
				2'd1: d1_reg <= byte_in;
				2'd2: d2_reg <= byte_in;
				2'd3: d2_reg <= d2_reg;
			endcase
		end
	end

	// Status read: opcode picks a byte, sent MSB first on falling edges.
	always_ff @(posedge clock) begin
		if (srst | s2_reg.cs_n | rst_pin) begin
			rd_reg <= 1'b0;
			rd_sel_reg <= 2'd0;
			out_cnt_reg <= 3'd0;
			do_out <= 1'b0;
			do_oe <= 1'b0;
		end else if (sclk_rise && bit_cnt_reg == 3'd7 && byte_cnt_reg == 2'd0) begin
			rd_reg <= is_rd & (mode_reg != MODE_SLEEP);
			rd_sel_reg <= byte_in[5:4];
			out_cnt_reg <= 3'd0;
		end else if (sclk_fall && rd_reg) begin
			unique case (rd_sel_reg)
				2'b00: do_out <= sr1[3'd7 - out_cnt_reg];
				2'b11: do_out <= sr2[3'd7 - out_cnt_reg];
				default: do_out <= sr3[3'd7 - out_cnt_reg];
			endcase
			do_oe <= 1'b1;
			out_cnt_reg <= out_cnt_reg + 3'd1;
		end
	end

	// Operating mode, busy timer and power-up delay.
	always_ff @(posedge clock) begin
		if (srst) begin
			mode_reg <= MODE_POWERUP;
			cnt_reg <= 16'd0;
			arr_reg <= 1'b0;
			sus_reg <= 1'b0;
		end else begin
			unique case (mode_reg)
				MODE_POWERUP: begin
					cnt_reg <= cnt_reg + 16'd1;
					if (cnt_reg == 16'(swp_pkg::PUW_CYC - 1)) begin
						mode_reg <= MODE_READY;
						cnt_reg <= 16'd0;
					end
				end
				MODE_READY: begin
					if (nv_wr || (go && is_pe && wel_reg && !sus_reg)) begin
						mode_reg <= MODE_BUSY;
						cnt_reg <= 16'(BUSY_CYCLES - 1);
						arr_reg <= is_pe;
					end else if (go && opcode_reg == swp_pkg::OP_RESM
						&& sus_reg) begin
						mode_reg <= MODE_BUSY;
						sus_reg <= 1'b0;
					end else if (go && opcode_reg == swp_pkg::OP_DPD) begin
						mode_reg <= MODE_SLEEP;
					end
				end
				MODE_BUSY: begin
					// Suspend is the one command a running array op takes.
					if (exec && arr_reg && opcode_reg == swp_pkg::OP_SUSP) begin
						mode_reg <= MODE_READY;
						sus_reg <= 1'b1;
					end else if (cnt_reg != 16'd0) begin
						cnt_reg <= cnt_reg - 16'd1;
					end else if (!exec) begin
						// Waits with the latch clear, or the latch would stay set.
						mode_reg <= MODE_READY;
						arr_reg <= 1'b0;
					end
				end
				MODE_SLEEP: begin
					if (exec && opcode_reg == swp_pkg::OP_REL) begin
						mode_reg <= MODE_READY;
					end
				end
			endcase
		end
	end

	// Write enable latch and volatile write enable.
	always_ff @(posedge clock) begin
		if (srst) begin
			wel_reg <= 1'b0;
			vwe_reg <= 1'b0;
		end else begin
			if (mode_reg == MODE_BUSY && cnt_reg == 16'd0 && !exec) begin
				wel_reg <= 1'b0;
			end else if (go && opcode_reg == swp_pkg::OP_WREN) begin
				wel_reg <= 1'b1;
			end else if (go && opcode_reg == swp_pkg::OP_WRDI) begin
				wel_reg <= 1'b0;
			end
			if (go) begin
				vwe_reg <= (opcode_reg == swp_pkg::OP_VWREN);
			end
		end
	end

	// Status copies; srst stands for a factory-fresh power-up.
	always_ff @(posedge clock) begin
		if (srst) begin
			nv1_reg <= swp_pkg::SR_RESET;
			nv2_reg <= swp_pkg::SR_RESET;
			nv3_reg <= swp_pkg::SR_RESET;
			vol1_reg <= swp_pkg::SR_RESET;
			vol2_reg <= swp_pkg::SR_RESET;
			vol3_reg <= swp_pkg::SR_RESET;
		end else if (nv_wr || v_wr) begin
			// Only configurable bits move; busy, latch and suspend live apart.
			if (opcode_reg == swp_pkg::OP_WRSR1) begin
				vol1_reg <= (vol1_reg & ~swp_pkg::SR1_CFG_MASK)
					| (d1_reg & swp_pkg::SR1_CFG_MASK);
				if (nv_wr) begin
					nv1_reg <= (nv1_reg & ~swp_pkg::SR1_CFG_MASK)
						| (d1_reg & swp_pkg::SR1_CFG_MASK);
				end
			end
			if ((opcode_reg == swp_pkg::OP_WRSR1 && byte_cnt_reg == 2'd3)
				|| opcode_reg == swp_pkg::OP_WRSR2) begin
				vol2_reg <= (vol2_reg & ~swp_pkg::SR2_CFG_MASK)
					| (w2 & swp_pkg::SR2_CFG_MASK);
				if (nv_wr) begin
					// Lock bits only ever gain ones.
					nv2_reg <= (nv2_reg & ~swp_pkg::SR2_CFG_MASK)
						| (w2 & swp_pkg::SR2_CFG_MASK)
						| (w2 & swp_pkg::SR2_OTP_MASK);
				end
			end
			if (opcode_reg == swp_pkg::OP_WRSR3) begin
				vol3_reg <= (vol3_reg & ~swp_pkg::SR3_CFG_MASK)
					| (d1_reg & swp_pkg::SR3_CFG_MASK);
				if (nv_wr) begin
					nv3_reg <= (nv3_reg & ~swp_pkg::SR3_CFG_MASK)
						| (d1_reg & swp_pkg::SR3_CFG_MASK);
				end
			end
		end
	end

	assign sr1 = {vol1_reg[7:2], wel_reg, mode_reg == MODE_BUSY};
	assign sr2 = {sus_reg, vol2_reg[6], nv2_reg[5:3], 1'b0, vol2_reg[1], 1'b0};
	assign sr3 = {vol3_reg[7:4], 4'h0};

	always_ff @(posedge clock) begin
		if (srst) begin
			status_byte_one <= 8'h00;
			status_byte_two <= 8'h00;
			status_byte_three <= 8'h00;
			cfg <= '0;
			drive_pct <= swp_pkg::PCT_00;
			hold_active <= 1'b0;
			pin_restart <= 1'b0;
			deep_sleep_state <= 1'b0;
		end else begin
			status_byte_one <= sr1;
			status_byte_two <= sr2;
			status_byte_three <= sr3;
			cfg <= {vol2_reg[1], vol3_reg[7:4], vol2_reg[6], vol1_reg[7:2]};
			unique case (vol3_reg[6:5])
				2'b00: drive_pct <= swp_pkg::PCT_00;
				2'b01: drive_pct <= swp_pkg::PCT_01;
				2'b10: drive_pct <= swp_pkg::PCT_10;
				2'b11: drive_pct <= swp_pkg::PCT_11;
			endcase
			hold_active <= hold_pin;
			pin_restart <= rst_pin;
			deep_sleep_state <= (mode_reg == MODE_SLEEP);
		end
	end

	property p_lock_refuse;
		@(posedge clock) disable iff (srst)
		exec && is_wr && locked |=> $stable(nv1_reg) && $stable(vol1_reg)
			&& $stable(nv2_reg) && $stable(vol3_reg);
	endproperty
	a_lock_refuse: assert property (p_lock_refuse)
		else $error("Locked status write changed a status byte.");
	property p_nv_write;
		@(posedge clock) disable iff (srst)
		nv_wr && opcode_reg == swp_pkg::OP_WRSR3
			|=> nv3_reg[7:4] == $past(d1_reg[7:4]) && vol3_reg == nv3_reg;
	endproperty
	a_nv_write: assert property (p_nv_write)
		else $error("Non-volatile status write not applied.");
	property p_vol_write;
		@(posedge clock) disable iff (srst)
		v_wr |=> $stable(nv1_reg) && $stable(nv2_reg) && $stable(nv3_reg);
	endproperty
	a_vol_write: assert property (p_vol_write)
		else $error("Volatile write touched non-volatile copy.");
	property p_volatile_bits;
		@(posedge clock) disable iff (srst)
		exec && is_wr && mode_reg == MODE_READY
			|=> wel_reg == $past(wel_reg) && sus_reg == $past(sus_reg);
	endproperty
	a_volatile_bits: assert property (p_volatile_bits)
		else $error("Status write altered latch or suspend flag.");
	property p_otp;
		@(posedge clock) disable iff (srst)
		##1 (nv2_reg[5:3] & $past(nv2_reg[5:3])) == $past(nv2_reg[5:3]);
	endproperty
	a_otp: assert property (p_otp)
		else $error("A one-time lock bit was cleared.");
	property p_powerup;
		@(posedge clock) disable iff (srst)
		mode_reg == MODE_POWERUP && exec |=> !wel_reg && !vwe_reg;
	endproperty
	a_powerup: assert property (p_powerup)
		else $error("Write enable taken during power-up delay.");
	property p_boundary;
		@(posedge clock) disable iff (srst)
		mode_reg == MODE_READY && cs_rise && bit_cnt_reg != 3'd0
			|=> $stable(wel_reg) && $stable(nv1_reg) && $stable(mode_reg);
	endproperty
	a_boundary: assert property (p_boundary)
		else $error("Partial-byte frame was executed.");
	property p_sleep;
		@(posedge clock) disable iff (srst)
		mode_reg == MODE_SLEEP && exec && opcode_reg != swp_pkg::OP_REL
			|=> mode_reg == MODE_SLEEP && $stable(wel_reg);
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("Command honoured in deep sleep.");
	property p_wel_clear;
		@(posedge clock) disable iff (srst)
		mode_reg == MODE_BUSY && cnt_reg == 16'd0 && !exec |=> !wel_reg
			&& mode_reg == MODE_READY;
	endproperty
	a_wel_clear: assert property (p_wel_clear)
		else $error("Enable latch survived end of write.");
	property p_wren;
		@(posedge clock) disable iff (srst)
		go && opcode_reg == swp_pkg::OP_WREN |=> wel_reg ##1 sr1[1];
	endproperty
	a_wren: assert property (p_wren)
		else $error("Write enable did not set the latch.");
endmodule

/* tb/swp_host.sv */
// Host controller model that drives the serial pins in mode 0.
`timescale 1ns/10ps
module swp_host (
	// Clock.
	input wire logic clock,
	// Side pins held by the bench.
	input wire logic wp_n,
	input wire logic hold_n,
	// Serial lines.
	input wire logic do_out,
	output swp_pkg::swp_pins_t pins
);
	logic cs_n = 1'b1;
	logic sclk = 1'b0;
	logic di = 1'b0;
	logic [7:0] rd = 8'h00;
	assign pins = '{cs_n: cs_n, sclk: sclk, di: di, wp_n: wp_n,
		hold_n: hold_n};
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Sends n bits of v from its top bit down; rd keeps the last byte seen.
	task automatic frame(input logic [39:0] v, input int n);
		step(1);
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			di = v[39 - i];
			step(4);
			sclk = 1'b1;
			rd = {rd[6:0], do_out};
			step(4);
			sclk = 1'b0;
		end
		step(4);
		cs_n = 1'b1;
		// The released line must not keep looking like valid data.
		di = ~di;
		step(8);
	endtask
endmodule

/* tb/tb_swp_status_protect.sv */
// Self-checking bench of the status write protection block.
`timescale 1ns/10ps
module tb_swp_status_protect;
	localparam int BUSY = 600;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic wp_n = 1'b1;
	logic hold_n = 1'b1;
	swp_pkg::swp_pins_t pins;
	logic do_out;
	logic do_oe;
	logic oe_seen = 1'b0;
	logic [7:0] sr1;
	logic [7:0] sr2;
	logic [7:0] sr3;
	swp_pkg::swp_cfg_t cfg;
	logic [6:0] drive_pct;
	logic hold_active;
	logic pin_restart;
	logic deep_sleep_state;
	logic [7:0] pct [4] = '{8'h32, 8'h19, 8'h4b, 8'h64};
	int bad_count = 0;
	int n_compared = 0;
	always #10 clock = ~clock;
	always @(posedge clock) begin
		if (do_oe === 1'b1) begin
			oe_seen <= 1'b1;
		end
	end
	swp_status_protect #(.BUSY_CYCLES(BUSY)) u_dut (
		.clock(clock),
		.srst(srst),
		.pins(pins),
		.do_out(do_out),
		.do_oe(do_oe),
		.status_byte_one(sr1),
		.status_byte_two(sr2),
		.status_byte_three(sr3),
		.cfg(cfg),
		.drive_pct(drive_pct),
		.hold_active(hold_active),
		.pin_restart(pin_restart),
		.deep_sleep_state(deep_sleep_state)
	);
	swp_host u_host (
		.clock(clock),
		.wp_n(wp_n),
		.hold_n(hold_n),
		.do_out(do_out),
		.pins(pins)
	);
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("ERROR %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic close_out;
		if (bad_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic cmd(input logic [7:0] op);
		u_host.frame({op, 32'h0}, 8);
	endtask
	task automatic wait_ready;
		int i;
		i = 0;
		while (sr1[0] !== 1'b0 && i < BUSY + 100) begin
			@(posedge clock);
			#1;
			i++;
		end
		check({7'h0, sr1[0]}, 8'h00);
	endtask
	// Non-volatile write: enable, write one byte, expect busy or not.
	task automatic nv(input logic [7:0] op, input logic [7:0] d,
		input logic go);
		cmd(swp_pkg::OP_WREN);
		u_host.frame({op, d, 24'h0}, 16);
		check({7'h0, sr1[0]}, {7'h0, go});
		wait_ready;
	endtask
	task automatic vol(input logic [7:0] op, input logic [7:0] d);
		cmd(swp_pkg::OP_VWREN);
		u_host.frame({op, d, 24'h0}, 16);
	endtask
	task automatic pin_probe(input logic hld, input logic rst);
		hold_n = 1'b0;
		repeat (6) @(posedge clock);
		#1;
		check({6'h0, hold_active, pin_restart}, {6'h0, hld, rst});
		hold_n = 1'b1;
		repeat (6) @(posedge clock);
		#1;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		close_out;
	end
	initial begin
		repeat (3) @(posedge clock);
		#1;
		check(sr1 | sr2 | sr3, 8'h00);
		check({1'b0, drive_pct}, 8'h32);
		srst = 1'b0;
		cmd(swp_pkg::OP_WREN);
		check(sr1, 8'h00);
		repeat (520) @(posedge clock);
		#1;
		cmd(swp_pkg::OP_WREN);
		check(sr1, 8'h02);
		u_host.frame({swp_pkg::OP_WRSR1, 32'h0}, 12);
		check(sr1, 8'h02);
		wp_n = 1'b0;
		nv(swp_pkg::OP_WRSR1, 8'h7f, 1'b1);
		check(sr1, 8'h7c);
		vol(swp_pkg::OP_WRSR1, 8'h80);
		check(sr1, 8'h80);
		nv(swp_pkg::OP_WRSR1, 8'h00, 1'b0);
		check(sr1 & 8'hfc, 8'h80);
		vol(swp_pkg::OP_WRSR1, 8'h00);
		check(sr1 & 8'hfc, 8'h80);
		wp_n = 1'b1;
		nv(swp_pkg::OP_WRSR1, 8'h00, 1'b1);
		check(sr1, 8'h00);
		for (int k = 0; k < 4; k++) begin
			vol(swp_pkg::OP_WRSR3, {1'b0, k[1:0], k[0], 4'h0});
			check(sr3, {1'b0, k[1:0], k[0], 4'h0});
			check({1'b0, drive_pct}, pct[k]);
			check({6'h0, cfg.drive_strength_field}, {6'h0, k[1:0]});
			check({7'h0, cfg.quad_fast_mode_bit}, {7'h0, k[0]});
		end
		pin_probe(1'b1, 1'b0);
		vol(swp_pkg::OP_WRSR3, 8'h80);
		pin_probe(1'b0, 1'b1);
		vol(swp_pkg::OP_WRSR2, 8'h02);
		check(sr2, 8'h02);
		check({7'h0, cfg.quad_io_enable}, 8'h01);
		pin_probe(1'b0, 1'b0);
		nv(swp_pkg::OP_WRSR3, 8'h20, 1'b1);
		check(sr3, 8'h20);
		nv(swp_pkg::OP_WRSR2, 8'h08, 1'b1);
		check(sr2, 8'h08);
		nv(swp_pkg::OP_WRSR2, 8'h00, 1'b1);
		check(sr2, 8'h08);
		vol(swp_pkg::OP_WRSR2, 8'h00);
		check(sr2, 8'h08);
		cmd(swp_pkg::OP_WREN);
		u_host.frame({swp_pkg::OP_PP, 32'h0}, 40);
		check({7'h0, sr1[0]}, 8'h01);
		u_host.frame({swp_pkg::OP_RDSR1, 32'h0}, 16);
		check(u_host.rd, 8'h03);
		vol(swp_pkg::OP_WRSR3, 8'h00);
		check(sr3, 8'h20);
		cmd(swp_pkg::OP_SUSP);
		check(sr2, 8'h88);
		cmd(swp_pkg::OP_RESM);
		check(sr2, 8'h08);
		wait_ready;
		check(sr1, 8'h00);
		cmd(swp_pkg::OP_DPD);
		check({7'h0, deep_sleep_state}, 8'h01);
		cmd(swp_pkg::OP_WREN);
		check(sr1, 8'h00);
		cmd(swp_pkg::OP_REL);
		check({7'h0, deep_sleep_state}, 8'h00);
		u_host.frame({swp_pkg::OP_RDSR2, 32'h0}, 16);
		check(u_host.rd, 8'h08);
		check({6'h0, oe_seen, do_oe}, 8'h02);
		srst = 1'b1;
		repeat (3) @(posedge clock);
		#1;
		check(sr1 | sr2 | sr3, 8'h00);
		srst = 1'b0;
		cmd(swp_pkg::OP_WREN);
		check(sr1, 8'h00);
		close_out;
	end
endmodule
